// >>> logic/plcs_regs.v
// express link capability, control and status register block on apb
// assumes apb master on pclk, link state inputs synchronous to pclk
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "plcs_defines.vh"

module plcs_regs (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output wire pslverr,
   output wire [31:0] prdata,
   input wire [1:0] req_strap_n,
   input wire [3:0] link_speed,
   input wire [5:0] link_width,
   input wire link_train_err,
   input wire link_training,
   input wire dll_active,
   output wire [1:0] aspm_ctrl,
   output wire common_clk_cfg,
   output wire ext_sync,
   output wire clkpm_en,
   output wire clkpm_capable
);

   // ****************************************************************
   // strap
   // ****************************************************************
   wire strap_en;

   plcs_strap u_strap (
      .pclk(pclk),
      .presetn(presetn),
      .req_strap_n(req_strap_n),
      .clkpm_strap_en(strap_en)
   );

   // ****************************************************************
   // apb decode
   // ****************************************************************
   wire hit_cap;
   wire hit_cs;
   wire mapped;
   wire setup;
   wire wr_access;
   wire wr_cs;

   assign hit_cap = (paddr == `PLCS_OFF_LINK_CAPABILITIES);
   assign hit_cs = (paddr == `PLCS_OFF_LINK_CTRL_STATUS);
   assign mapped = hit_cap | hit_cs;
   assign setup = psel & ~penable;
   assign wr_access = psel & penable & pwrite;
   // capability writes are dropped outright
   assign wr_cs = wr_access & hit_cs;

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ****************************************************************
   // link control
   // ****************************************************************
   reg [1:0] aspm_q;
   reg [1:0] aspm_d;
   reg ccc_q;
   reg ccc_d;
   reg xsync_q;
   reg xsync_d;
   reg clkpm_q;
   reg clkpm_d;

   always @* begin
      aspm_d = aspm_q;
      ccc_d = ccc_q;
      xsync_d = xsync_q;
      clkpm_d = clkpm_q;
      if (wr_cs && pstrb[0]) begin
         aspm_d = pwdata[`PLCS_CTL_ASPM_LSB +: 2];
         ccc_d = pwdata[`PLCS_CTL_CCC_BIT];
         xsync_d = pwdata[`PLCS_CTL_XSYNC_BIT];
      end
      if (wr_cs && pstrb[1] && strap_en) begin
         clkpm_d = pwdata[`PLCS_CTL_CLKPM_BIT];
      end
      // a bit that cannot be written never leaves zero
      if (!strap_en) begin
         clkpm_d = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aspm_q <= `PLCS_ASPM_RST;
         ccc_q <= 1'b0;
         xsync_q <= 1'b0;
         clkpm_q <= 1'b0;
      end else begin
         aspm_q <= aspm_d;
         ccc_q <= ccc_d;
         xsync_q <= xsync_d;
         clkpm_q <= clkpm_d;
      end
   end

   assign aspm_ctrl = aspm_q;
   assign common_clk_cfg = ccc_q;
   assign ext_sync = xsync_q;
   assign clkpm_en = clkpm_q;
   assign clkpm_capable = strap_en;

   // ****************************************************************
   // link status capture
   // ****************************************************************
   reg [3:0] speed_q;
   reg [5:0] width_q;
   reg terr_q;
   reg train_q;
   reg dll_down_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_q <= `PLCS_SPEED_2G5;
         width_q <= `PLCS_WIDTH_X1;
         terr_q <= 1'b0;
         train_q <= 1'b0;
         dll_down_q <= 1'b0;
      end else begin
         speed_q <= link_speed;
         width_q <= link_width;
         terr_q <= link_train_err;
         train_q <= link_training;
         dll_down_q <= ~dll_active;
      end
   end

   // ****************************************************************
   // read words
   // ****************************************************************
   reg [31:0] cap_word;
   reg [31:0] cs_word;

   always @* begin
      cap_word = 32'h0000_0000;
      cap_word[`PLCS_CAP_SPEED_LSB +: 4] = `PLCS_SPEED_2G5;
      cap_word[`PLCS_CAP_WIDTH_LSB +: 6] = `PLCS_MAX_WIDTH;
      cap_word[`PLCS_CAP_ASPM_LSB +: 2] = `PLCS_ASPM_L0S_L1;
      cap_word[`PLCS_CAP_L0S_LAT_LSB +: 3] = `PLCS_L0S_LAT;
      if (strap_en) begin
         cap_word[`PLCS_CAP_L1_LAT_LSB +: 3] = `PLCS_L1_LAT_ON;
      end else begin
         cap_word[`PLCS_CAP_L1_LAT_LSB +: 3] = `PLCS_L1_LAT_OFF;
      end
      cap_word[`PLCS_CAP_CLKPM_BIT] = strap_en;
      cap_word[`PLCS_CAP_PORT_LSB +: 8] = `PLCS_PORT_NUM;
   end

   always @* begin
      cs_word = 32'h0000_0000;
      cs_word[`PLCS_CTL_ASPM_LSB +: 2] = aspm_q;
      cs_word[`PLCS_CTL_RCB_BIT] = 1'b0;
      cs_word[`PLCS_CTL_CCC_BIT] = ccc_q;
      cs_word[`PLCS_CTL_XSYNC_BIT] = xsync_q;
      cs_word[`PLCS_CTL_CLKPM_BIT] = clkpm_q;
      cs_word[`PLCS_STS_SPEED_LSB +: 4] = speed_q;
      cs_word[`PLCS_STS_WIDTH_LSB +: 6] = width_q;
      cs_word[`PLCS_STS_TERR_BIT] = terr_q;
      cs_word[`PLCS_STS_TRAIN_BIT] = train_q;
      cs_word[`PLCS_STS_SCC_BIT] = `PLCS_SCC_RST;
      cs_word[`PLCS_STS_DLL_BIT] = dll_down_q;
   end

   // ****************************************************************
   // read data register
   // ****************************************************************
   // loaded in the setup cycle so it is stable through the access phase
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;

   always @* begin
      rdata_d = rdata_q;
      if (setup && !pwrite) begin
         if (hit_cap) begin
            rdata_d = cap_word;
         end else if (hit_cs) begin
            rdata_d = cs_word;
         end else begin
            rdata_d = 32'h0000_0000;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;

endmodule // plcs_regs

// >>> logic/plcs_defines.vh
// constants for the express link capability, control and status registers
// assumes inclusion by the register block and its strap sampler only
`ifndef PLCS_DEFINES_VH
`define PLCS_DEFINES_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define PLCS_OFF_LINK_CAPABILITIES 8'hbc
`define PLCS_OFF_LINK_CTRL_STATUS 8'hc0

// ****************************************************************
// capability fields
// ****************************************************************
`define PLCS_CAP_SPEED_LSB 0
`define PLCS_CAP_WIDTH_LSB 4
`define PLCS_CAP_ASPM_LSB 10
`define PLCS_CAP_L0S_LAT_LSB 12
`define PLCS_CAP_L1_LAT_LSB 15
`define PLCS_CAP_CLKPM_BIT 18
`define PLCS_CAP_PORT_LSB 24
`define PLCS_SPEED_2G5 4'h1
`define PLCS_WIDTH_X1 6'h01
`define PLCS_WIDTH_X4 6'h04
`define PLCS_MAX_WIDTH 6'h01
`define PLCS_ASPM_L0S_L1 2'h3
`define PLCS_L0S_LAT 3'h3
`define PLCS_L1_LAT_OFF 3'h0
`define PLCS_L1_LAT_ON 3'h6
`define PLCS_PORT_NUM 8'h00

// ****************************************************************
// control fields
// ****************************************************************
`define PLCS_CTL_ASPM_LSB 0
`define PLCS_CTL_RCB_BIT 3
`define PLCS_CTL_CCC_BIT 6
`define PLCS_CTL_XSYNC_BIT 7
`define PLCS_CTL_CLKPM_BIT 8
`define PLCS_ASPM_RST 2'h0

// ****************************************************************
// status fields
// ****************************************************************
`define PLCS_STS_SPEED_LSB 16
`define PLCS_STS_WIDTH_LSB 20
`define PLCS_STS_TERR_BIT 26
`define PLCS_STS_TRAIN_BIT 27
`define PLCS_STS_SCC_BIT 28
`define PLCS_STS_DLL_BIT 29
`define PLCS_SCC_RST 1'b1

// ****************************************************************
// strap
// ****************************************************************
`define PLCS_STRAP_ON 2'h0

`endif

// >>> logic/plcs_strap.v
// strap sampler: catches the clock power management request straps once
// assumes the straps are steady around the release of presetn
`timescale 1ns/1ps
`include "plcs_defines.vh"

module plcs_strap (
   input wire pclk,
   input wire presetn,
   input wire [1:0] req_strap_n,
   output wire clkpm_strap_en
);

   // ****************************************************************
   // capture at the first edge after reset release
   // ****************************************************************
   reg taken_q;
   reg en_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         taken_q <= 1'b0;
         en_q <= 1'b0;
      end else if (!taken_q) begin
         taken_q <= 1'b1;
         en_q <= (req_strap_n == `PLCS_STRAP_ON);
      end
   end

   // held until the next reset
   assign clkpm_strap_en = en_q;

endmodule // plcs_strap

// >>> bench/plcs_regs_assertions.sv
// checker on the link register block ports
// assumes zero-wait apb on pclk, presetn async active low
`timescale 1ns/1ps
module plcs_regs_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic [1:0] aspm_ctrl,
   input wire logic clkpm_en,
   input wire logic clkpm_capable
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_rcap;
      psel && penable && !pwrite && paddr == 8'hbc;
   endsequence
   sequence s_rctl;
      psel && penable && !pwrite && paddr == 8'hc0;
   endsequence
   sequence s_wctl;
      psel && penable && pwrite && paddr == 8'hc0;
   endsequence
   AST_SPD: assert property (s_rcap |-> prdata[3:0] == 4'h1) else $error("speed");
   AST_WID: assert property (s_rcap |-> $onehot(prdata[9:4])) else $error("width");
   AST_PMS: assert property (s_rcap |-> prdata[11:10] == 2'h3) else $error("pm");
   AST_L1LAT: assert property (s_rcap |-> prdata[17:15] == 3'h6 * clkpm_capable)
      else $error("l1 latency");
   AST_CPCAP: assert property (s_rcap |-> prdata[18] == clkpm_capable) else $error("cap");
   AST_HOLD: assert property (presetn [*3] |-> $stable(clkpm_capable)) else $error("strap");
   AST_ASPM: assert property (s_wctl ##0 pstrb[0] |=> aspm_ctrl == $past(pwdata[1:0]))
      else $error("aspm");
   AST_ASPM_KEEP: assert property (s_wctl ##0 !pstrb[0] |=> $stable(aspm_ctrl))
      else $error("aspm changed without strobe");
   AST_RCB: assert property (s_rctl |-> !prdata[3]) else $error("rcb");
   AST_CPEN: assert property (s_wctl ##0 pstrb[1] |=>
      clkpm_en == ($past(pwdata[8]) && clkpm_capable)) else $error("clkpm enable");
endmodule // plcs_regs_assertions

// >>> bench/plcs_link_partner.sv
// link partner model: reports link state after one training step
// assumes lanes changes just after a clock edge
`timescale 1ns/1ps
module plcs_link_partner (
   input wire pclk,
   input wire presetn,
   input wire [5:0] lanes,
   output reg [3:0] link_speed,
   output reg [5:0] link_width,
   output reg link_train_err,
   output reg link_training,
   output reg dll_active
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_speed <= 4'h1;
         link_width <= 6'h01;
         link_train_err <= 1'b0;
         link_training <= 1'b0;
         dll_active <= 1'b0;
      end else begin
         link_width <= lanes;
         link_training <= lanes != link_width;
         link_train_err <= lanes == 6'h00;
         dll_active <= lanes != 6'h00 && !link_training;
      end
   end
endmodule // plcs_link_partner

// >>> bench/pcie_link_cap_ctrl_status_tb.sv
// testbench: apb tasks, strap resets and link partner against a model
// assumes plcs_regs as top, zero-wait apb slave
`timescale 1ns/1ps
module pcie_link_cap_ctrl_status_tb;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0, rd;
   reg [3:0] pstrb = 4'h0;
   reg [1:0] strap_n = 2'h3;
   reg [5:0] lanes = 6'h01;
   wire pready, pslverr, terr, trn, dll, cc, xs, cpe, cap;
   wire [31:0] prdata;
   wire [3:0] spd;
   wire [5:0] wid;
   wire [1:0] aspm;
   wire lz = lanes == 6'h00;
   integer n_errors = 0, cmp_count = 0, cp, ctl, i, k, s, w, b;
   always #2 pclk = ~pclk;
   plcs_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .req_strap_n(strap_n), .link_speed(spd),
      .link_width(wid), .link_train_err(terr), .link_training(trn), .dll_active(dll),
      .aspm_ctrl(aspm), .common_clk_cfg(cc), .ext_sync(xs), .clkpm_en(cpe),
      .clkpm_capable(cap));
   plcs_link_partner lp (.pclk(pclk), .presetn(presetn), .lanes(lanes), .link_speed(spd),
      .link_width(wid), .link_train_err(terr), .link_training(trn), .dll_active(dll));
   task chk(input [31:0] e, input [31:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
         end
      end
   endtask
   task final_report;
      begin
         $display("compares %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d, input [3:0] b);
      integer t;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         pstrb <= b;
         @(posedge pclk);
         penable <= 1'b1;
         t = 0;
         do begin
            @(posedge pclk);
            t = t + 1;
         end while (pready !== 1'b1 && t < 40);
         if (pready !== 1'b1) begin
            n_errors = n_errors + 1;
            final_report;
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task run(input [1:0] sn);
      begin
         presetn <= 1'b0;
         strap_n <= sn;
         repeat (2) @(posedge pclk);
         presetn <= 1'b1;
         repeat (2) @(posedge pclk);
         strap_n <= ~sn;
         cp = sn == 2'h0;
         for (i = 0; i < 2; i = i + 1) begin
            apb(0, 8'hbc, 0, 0);
            chk(1 | 1 << 4 | 3 << 10 | 3 << 12 | cp * (6 << 15 | 1 << 18), rd);
            chk(cp, cap);
            apb(1, 8'hbc, $urandom, 4'hf);
         end
         ctl = 0;
         for (i = 0; i < 8; i = i + 1) begin
            k = $urandom;
            w = {k[31:9], i[0], k[7:2], i[1:0]};
            b = i < 4 ? 3 : k[10:9];
            apb(1, 8'hc0, w, b[3:0]);
            // model: lane 0 carries bits 7:6 and 1:0, lane 1 bit 8, which needs the strap
            if (b[0]) ctl = ctl & 32'h100 | w & 32'hc3;
            if (b[1] && cp) ctl = ctl & 32'hc3 | w & 32'h100;
            apb(0, 8'hc0, 0, 0);
            chk(ctl, rd[15:0]);
            chk(ctl, {cpe, xs, cc, 4'h0, aspm});
         end
         for (i = 0; i < 3; i = i + 1) begin
            lanes <= 6'h01 << (3 * i);
            repeat (4) @(posedge pclk);
            apb(0, 8'hc0, 0, 0);
            chk({2'h0, lz, 1'b1, 1'b0, lz, lanes, 4'h1}, rd[31:16]);
         end
         $display("strap %h test done", sn);
      end
   endtask
   initial begin
      k = $urandom(31);
      @(posedge pclk);
      for (s = 0; s < 3; s = s + 1) begin
         run(s ? 2'(s - 1) : 2'h3);
      end
      apb(1, 8'h40, 32'hffff_ffff, 4'hf);
      chk(32'h1, err);
      apb(0, 8'h40, 0, 0);
      chk(32'h1, err);
      chk(32'h0, rd);
      $display("unmapped test done");
      final_report;
   end
endmodule // pcie_link_cap_ctrl_status_tb
bind plcs_regs plcs_regs_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .aspm_ctrl(aspm_ctrl), .clkpm_en(clkpm_en), .clkpm_capable(clkpm_capable));
